// ==== rtl/timer_channel_mode_config.sv ====
// capture/compare channel mode block: two mode registers, input filter,
// capture source routing, event prescaler and output compare reference logic
// assumes the counter, update event and trigger signals come from the
// surrounding timer and are synchronous to i_sys_clk
//
// How it works
// - ch1 select: output, input1, input2, trigger
// - ch1 select frozen while ch1 enabled
// - trigger routing works only with internal trigger
// - prescaler captures every 1,2,4,8 events
// - filter code table; zero samples at deadtime
// - filter samples clock/div, flips after N
// - ch2 select: output, input1, input2, trigger
// - ch2 select frozen while ch2 enabled
// - ch2 prescaler 11:10, filter 15:12
// - second mode register 0x1C mirrors first
// - ch3 select: output, input3, input4, trigger
// - ch3 select frozen while ch3 enabled
// - ch3 fast bit shortens trigger response
// - ch3 preload bit 3, mode 6:4
// - ch3 clear bit: trigger high forces low
// - ch4 select: output, input4, input3, trigger
// - ch4 select frozen while ch4 enabled
// - ch4 fast 10, preload 11, mode 14:12, clear 15
// - compare mode codes freeze to pwm2
// - preload defers compare value to update
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "timer_channel_mode_config_defs.svh"

module timer_channel_mode_config (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // register port
  input wire logic [`TCM_ADDR_W-1:0] i_addr,
  input wire logic [`TCM_DATA_W-1:0] i_wr_data,
  input wire logic i_wr_strobe,
  input wire logic i_rd_strobe,
  output logic [`TCM_DATA_W-1:0] o_rd_data,
  // channel side
  input wire logic [`TCM_CHANNELS-1:0] i_timer_input,
  input wire logic i_internal_trigger_source,
  input wire logic i_internal_trigger_chosen,
  input wire logic i_deadtime_sample_clock,
  input wire logic i_trigger_event,
  input wire logic i_filtered_external_trigger,
  // counter side
  input wire logic [`TCM_REG_W-1:0] i_counter,
  input wire logic i_update_event,
  // results
  output logic [`TCM_CHANNELS-1:0] o_reference_output,
  output logic [`TCM_CHANNELS-1:0] o_capture_event,
  output logic [`TCM_CHANNELS-1:0] o_filtered_input,
  output logic [`TCM_CHANNELS-1:0] o_channel_enable
);

  // own and partner timer input for each channel, index = channel
  localparam logic [1:0] OWN_INPUT [0:3] = '{2'h0, 2'h0, 2'h2, 2'h3};
  localparam logic [1:0] PARTNER_INPUT [0:3] = '{2'h1, 2'h1, 2'h3, 2'h2};

  // registered state and its next value
  timer_channel_mode_config_pkg::state_s state_r;
  timer_channel_mode_config_pkg::state_s state_nxt;

  // one channel's byte out of the two mode registers
  function automatic logic [7:0] chan_byte(input logic [15:0] m12, input logic [15:0] m34, input int ch);
    logic [15:0] m;
    m = (ch < 2) ? m12 : m34;
    chan_byte = (ch % 2 == 0) ? m[7:0] : m[15:8];
  endfunction : chan_byte

  // mode register write; a select field keeps its value while its channel is on
  function automatic logic [15:0] mode_write(input logic [15:0] old_v, input logic [15:0] new_v,
                                             input logic [1:0] en);
    logic [15:0] v;
    v = new_v;
    if (en[0]) begin
      v[`TCM_SEL_LSB +: 2] = old_v[`TCM_SEL_LSB +: 2];
    end
    if (en[1]) begin
      v[8 + `TCM_SEL_LSB +: 2] = old_v[8 + `TCM_SEL_LSB +: 2];
    end
    mode_write = v;
  endfunction : mode_write

  // filter code to {divider minus one, length}
  function automatic logic [8:0] filter_cfg(input logic [3:0] code);
    logic [4:0] dm1;
    logic [3:0] len;
    dm1 = 5'h00;
    len = 4'h1;
    case (code)
      4'h1: begin dm1 = 5'h00; len = 4'h2; end
      4'h2: begin dm1 = 5'h00; len = 4'h4; end
      4'h3: begin dm1 = 5'h00; len = 4'h8; end
      4'h4: begin dm1 = 5'h01; len = 4'h6; end
      4'h5: begin dm1 = 5'h01; len = 4'h8; end
      4'h6: begin dm1 = 5'h03; len = 4'h6; end
      4'h7: begin dm1 = 5'h03; len = 4'h8; end
      4'h8: begin dm1 = 5'h07; len = 4'h6; end
      4'h9: begin dm1 = 5'h07; len = 4'h8; end
      4'hA: begin dm1 = 5'h0F; len = 4'h5; end
      4'hB: begin dm1 = 5'h0F; len = 4'h6; end
      4'hC: begin dm1 = 5'h0F; len = 4'h8; end
      4'hD: begin dm1 = 5'h1F; len = 4'h5; end
      4'hE: begin dm1 = 5'h1F; len = 4'h6; end
      4'hF: begin dm1 = 5'h1F; len = 4'h8; end
      default: begin dm1 = 5'h00; len = 4'h1; end
    endcase
    filter_cfg = {dm1, len};
  endfunction : filter_cfg

  // next reference level for one output channel
  function automatic logic next_ref(input logic [2:0] code, input logic cur, input logic [15:0] cnt,
                                    input logic [15:0] cmp, input logic fast_hit);
    logic match;
    match = (cnt == cmp) || fast_hit;
    case (timer_channel_mode_config_pkg::oc_mode_e'(code))
      timer_channel_mode_config_pkg::OC_FREEZE: next_ref = cur;
      timer_channel_mode_config_pkg::OC_SET_ON_MATCH: next_ref = match ? 1'b1 : cur;
      timer_channel_mode_config_pkg::OC_CLEAR_ON_MATCH: next_ref = match ? 1'b0 : cur;
      timer_channel_mode_config_pkg::OC_TOGGLE_ON_MATCH: next_ref = match ? ~cur : cur;
      timer_channel_mode_config_pkg::OC_FORCE_LOW: next_ref = 1'b0;
      timer_channel_mode_config_pkg::OC_FORCE_HIGH: next_ref = 1'b1;
      // pwm: a fast trigger acts as the match edge
      timer_channel_mode_config_pkg::OC_PWM1: next_ref = fast_hit ? 1'b0 : (cnt < cmp);
      timer_channel_mode_config_pkg::OC_PWM2: next_ref = fast_hit ? 1'b1 : (cnt > cmp);
      default: next_ref = cur;
    endcase
  endfunction : next_ref

  // next-state logic for registers, filters, capture path and compare path
  always_comb begin
    logic [7:0] cfg;
    logic [8:0] fcfg;
    logic [1:0] sel;
    logic [1:0] psc;
    logic cap_in;
    logic sample;
    logic [2:0] ratio_m1;
    logic [2:0] cmp_idx;
    cfg = 8'h00;
    fcfg = 9'h000;
    sel = 2'h0;
    psc = 2'h0;
    cap_in = 1'b0;
    sample = 1'b0;
    ratio_m1 = 3'h0;
    cmp_idx = 3'h0;
    state_nxt = state_r;
    state_nxt.rd_data = {`TCM_DATA_W{1'b0}};

    // register writes
    if (i_wr_strobe) begin
      case (i_addr)
        `TCM_OFS_MODE_CH1_CH2: begin
          state_nxt.mode_ch1_ch2 = mode_write(state_r.mode_ch1_ch2, i_wr_data[15:0], state_r.enable[1:0]);
        end
        `TCM_OFS_MODE_CH3_CH4: begin
          state_nxt.mode_ch3_ch4 = mode_write(state_r.mode_ch3_ch4, i_wr_data[15:0], state_r.enable[3:2]);
        end
        `TCM_OFS_ENABLE: begin
          state_nxt.enable = i_wr_data[`TCM_CHANNELS-1:0];
        end
        `TCM_OFS_STATUS: begin
          // status is read-only
        end
        default: begin
          // compare value words, everything else ignored
          if (i_addr >= `TCM_OFS_CMP_BASE && i_addr <= `TCM_OFS_CMP_LAST && i_addr[1:0] == 2'h0) begin
            cmp_idx = 3'(i_addr[4:2] - 3'h2);
            state_nxt.cmp_written[cmp_idx[1:0]] = i_wr_data[15:0];
          end
        end
      endcase
    end

    // register reads, data stand in the next cycle
    if (i_rd_strobe) begin
      case (i_addr)
        `TCM_OFS_MODE_CH1_CH2: state_nxt.rd_data = {16'h0000, state_r.mode_ch1_ch2};
        `TCM_OFS_MODE_CH3_CH4: state_nxt.rd_data = {16'h0000, state_r.mode_ch3_ch4};
        `TCM_OFS_ENABLE: state_nxt.rd_data = {28'h0000000, state_r.enable};
        `TCM_OFS_STATUS: begin
          state_nxt.rd_data = {20'h00000, state_r.cap_prev, state_r.ref_level, state_r.filtered};
        end
        default: begin
          if (i_addr >= `TCM_OFS_CMP_BASE && i_addr <= `TCM_OFS_CMP_LAST && i_addr[1:0] == 2'h0) begin
            cmp_idx = 3'(i_addr[4:2] - 3'h2);
            state_nxt.rd_data = {16'h0000, state_r.cmp_active[cmp_idx[1:0]]};
          end
        end
      endcase
    end

    // per-channel datapath
    for (int ch = 0; ch < `TCM_CHANNELS; ch++) begin
      cfg = chan_byte(state_r.mode_ch1_ch2, state_r.mode_ch3_ch4, ch);
      sel = cfg[`TCM_SEL_LSB +: 2];
      psc = cfg[`TCM_PSC_LSB +: 2];
      fcfg = filter_cfg(cfg[`TCM_FILT_LSB +: 4]);

      // input filter on timer input ch, using that channel's filter code
      if (cfg[`TCM_FILT_LSB +: 4] == 4'h0) begin
        // no filtering: follow the input at the deadtime sample rate
        state_nxt.div_cnt[ch] = 5'h00;
        state_nxt.run_cnt[ch] = 4'h0;
        if (i_deadtime_sample_clock) begin
          state_nxt.filtered[ch] = i_timer_input[ch];
        end
      end else begin
        // sample once every divider cycles
        sample = (state_r.div_cnt[ch] >= fcfg[8:4]);
        state_nxt.div_cnt[ch] = sample ? 5'h00 : 5'(state_r.div_cnt[ch] + 5'h01);
        if (sample) begin
          if (i_timer_input[ch] != state_r.filtered[ch]) begin
            // flip only after N samples in a row at the new level
            if (4'(state_r.run_cnt[ch] + 4'h1) >= fcfg[3:0]) begin
              state_nxt.filtered[ch] = i_timer_input[ch];
              state_nxt.run_cnt[ch] = 4'h0;
            end else begin
              state_nxt.run_cnt[ch] = 4'(state_r.run_cnt[ch] + 4'h1);
            end
          end else begin
            state_nxt.run_cnt[ch] = 4'h0;
          end
        end
      end

      // capture input routing
      case (sel)
        `TCM_SEL_OWN: cap_in = state_r.filtered[OWN_INPUT[ch]];
        `TCM_SEL_PARTNER: cap_in = state_r.filtered[PARTNER_INPUT[ch]];
        // trigger source counts only while an internal trigger is chosen
        `TCM_SEL_TRIGGER: cap_in = i_internal_trigger_source & i_internal_trigger_chosen;
        default: cap_in = 1'b0;
      endcase
      state_nxt.cap_prev[ch] = cap_in;

      // prescaler on rising capture-input edges
      ratio_m1 = 3'((4'h1 << psc) - 4'h1);
      state_nxt.psc_prev[ch] = psc;
      state_nxt.cap_event[ch] = 1'b0;
      if (!state_r.enable[ch] || sel == `TCM_SEL_OUTPUT || psc != state_r.psc_prev[ch]) begin
        state_nxt.psc_cnt[ch] = 3'h0;
      end else if (cap_in && !state_r.cap_prev[ch]) begin
        if (state_r.psc_cnt[ch] >= ratio_m1) begin
          state_nxt.cap_event[ch] = 1'b1;
          state_nxt.psc_cnt[ch] = 3'h0;
        end else begin
          state_nxt.psc_cnt[ch] = 3'(state_r.psc_cnt[ch] + 3'h1);
        end
      end

      // compare value: direct or on update event
      if (!cfg[`TCM_PRELOAD_BIT]) begin
        state_nxt.cmp_active[ch] = state_nxt.cmp_written[ch];
      end else if (i_update_event) begin
        state_nxt.cmp_active[ch] = state_r.cmp_written[ch];
      end

      // reference output
      if (sel != `TCM_SEL_OUTPUT) begin
        state_nxt.ref_level[ch] = 1'b0;
      end else if (cfg[`TCM_CLEAR_BIT] && i_filtered_external_trigger) begin
        state_nxt.ref_level[ch] = 1'b0;
      end else begin
        state_nxt.ref_level[ch] = next_ref(cfg[`TCM_MODE_LSB +: 3], state_r.ref_level[ch], i_counter,
                                           state_r.cmp_active[ch],
                                           cfg[`TCM_FAST_BIT] & i_trigger_event);
      end
    end
  end

  // state register with synchronous reset
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      state_r <= '0;
      state_r.mode_ch1_ch2 <= `TCM_MODE_RESET;
      state_r.mode_ch3_ch4 <= `TCM_MODE_RESET;
      state_r.enable <= `TCM_ENABLE_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // outputs straight from the state register
  assign o_rd_data = state_r.rd_data;
  assign o_reference_output = state_r.ref_level;
  assign o_capture_event = state_r.cap_event;
  assign o_filtered_input = state_r.filtered;
  assign o_channel_enable = state_r.enable;

endmodule : timer_channel_mode_config
`default_nettype wire

// ==== rtl/timer_channel_mode_config_defs.svh ====
// register offsets, field positions, reset values and widths for the channel mode block
// assumes a 32-bit plain register port with byte addresses
`ifndef TIMER_CHANNEL_MODE_CONFIG_DEFS_SVH
`define TIMER_CHANNEL_MODE_CONFIG_DEFS_SVH

// register byte offsets
`define TCM_OFS_MODE_CH1_CH2 8'h18
`define TCM_OFS_MODE_CH3_CH4 8'h1C
`define TCM_OFS_ENABLE 8'h20
`define TCM_OFS_STATUS 8'h24
`define TCM_OFS_CMP_BASE 8'h28
`define TCM_OFS_CMP_LAST 8'h34

// widths
`define TCM_ADDR_W 8
`define TCM_DATA_W 32
`define TCM_REG_W 16
`define TCM_CHANNELS 4

// reset values
`define TCM_MODE_RESET 16'h0000
`define TCM_ENABLE_RESET 4'h0
`define TCM_CMP_RESET 16'h0000

// field positions inside one channel byte
`define TCM_SEL_LSB 0
`define TCM_FAST_BIT 2
`define TCM_PRELOAD_BIT 3
`define TCM_MODE_LSB 4
`define TCM_CLEAR_BIT 7
`define TCM_PSC_LSB 2
`define TCM_FILT_LSB 4

// direction select codes
`define TCM_SEL_OUTPUT 2'h0
`define TCM_SEL_OWN 2'h1
`define TCM_SEL_PARTNER 2'h2
`define TCM_SEL_TRIGGER 2'h3

`endif

// ==== rtl/timer_channel_mode_config_pkg.sv ====
// types shared by the channel mode block: compare modes and the state record
// assumes the defs header is on the include path
`include "timer_channel_mode_config_defs.svh"

package timer_channel_mode_config_pkg;

  // output compare mode codes, in field order
  typedef enum logic [2:0] {
    OC_FREEZE,
    OC_SET_ON_MATCH,
    OC_CLEAR_ON_MATCH,
    OC_TOGGLE_ON_MATCH,
    OC_FORCE_LOW,
    OC_FORCE_HIGH,
    OC_PWM1,
    OC_PWM2
  } oc_mode_e;

  // complete state of the block
  typedef struct packed {
    logic [`TCM_REG_W-1:0] mode_ch1_ch2;                      // channel mode register 1/2
    logic [`TCM_REG_W-1:0] mode_ch3_ch4;                      // channel mode register 3/4
    logic [`TCM_CHANNELS-1:0] enable;                         // per-channel enable
    logic [`TCM_CHANNELS-1:0][`TCM_REG_W-1:0] cmp_written;    // compare value as written
    logic [`TCM_CHANNELS-1:0][`TCM_REG_W-1:0] cmp_active;     // compare value in use
    logic [`TCM_CHANNELS-1:0][4:0] div_cnt;                   // filter sample divider
    logic [`TCM_CHANNELS-1:0][3:0] run_cnt;                   // filter stable-sample count
    logic [`TCM_CHANNELS-1:0] filtered;                       // filtered timer inputs
    logic [`TCM_CHANNELS-1:0] cap_prev;                       // last capture input level
    logic [`TCM_CHANNELS-1:0][2:0] psc_cnt;                   // prescaler event count
    logic [`TCM_CHANNELS-1:0][1:0] psc_prev;                  // prescaler code last cycle
    logic [`TCM_CHANNELS-1:0] ref_level;                      // reference outputs
    logic [`TCM_CHANNELS-1:0] cap_event;                      // capture pulses
    logic [`TCM_DATA_W-1:0] rd_data;                          // read data
  } state_s;

endpackage : timer_channel_mode_config_pkg

// ==== test/timer_channel_mode_config_chk.sv ====
// assertions on the ports of the channel mode block
// assumes a bind to the top module and one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "timer_channel_mode_config_defs.svh"

module timer_channel_mode_config_chk (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // register port
  input wire logic [`TCM_ADDR_W-1:0] i_addr,
  input wire logic [`TCM_DATA_W-1:0] i_wr_data,
  input wire logic i_wr_strobe,
  input wire logic i_rd_strobe,
  input wire logic [`TCM_DATA_W-1:0] o_rd_data,
  // channel side
  input wire logic i_filtered_external_trigger,
  input wire logic [`TCM_CHANNELS-1:0] o_reference_output,
  input wire logic [`TCM_CHANNELS-1:0] o_capture_event,
  input wire logic [`TCM_CHANNELS-1:0] o_channel_enable
);
  // shadow of the ch3/ch4 mode register; a select stays put while enabled
  logic [15:0] m34_r;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      m34_r <= 16'h0000;
    end else if (i_wr_strobe && i_addr == 8'h1C) begin
      m34_r <= {i_wr_data[15:10], o_channel_enable[3] ? m34_r[9:8] : i_wr_data[9:8],
                i_wr_data[7:2], o_channel_enable[2] ? m34_r[1:0] : i_wr_data[1:0]};
    end
  end

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  a_rd_idle_zero: assert property (!$past(i_rd_strobe) |-> o_rd_data == 32'h0)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (i_rd_strobe && !(i_addr inside {8'h18, 8'h1C, 8'h20, 8'h24,
    8'h28, 8'h2C, 8'h30, 8'h34}) |=> o_rd_data == 32'h0)
    else $error("unmapped read not zero");
  a_mode34_read: assert property (i_rd_strobe && i_addr == 8'h1C |=> o_rd_data == {16'h0, $past(m34_r)})
    else $error("mode register 3/4 read wrong");
  a_enable_write: assert property (i_wr_strobe && i_addr == 8'h20 |=> o_channel_enable == $past(i_wr_data[3:0]))
    else $error("enable bits not written");
  a_cap_enabled: assert property ((o_capture_event & ~$past(o_channel_enable)) == 4'h0)
    else $error("capture on a disabled channel");
  a_cap_one_cycle: assert property ((o_capture_event & $past(o_capture_event)) == 4'h0)
    else $error("capture pulse longer than one cycle");
  a_clear_wins: assert property (m34_r[1:0] == 2'h0 && m34_r[7] && i_filtered_external_trigger
    |=> !o_reference_output[2])
    else $error("trigger clear did not force reference low");
  a_force_high: assert property (m34_r[1:0] == 2'h0 && m34_r[6:4] == 3'h5 && !m34_r[7]
    |=> o_reference_output[2])
    else $error("forced high reference not high");
  a_force_low_ch4: assert property (m34_r[9:8] == 2'h0 && m34_r[14:12] == 3'h4 |=> !o_reference_output[3])
    else $error("forced low reference not low");
  a_input_ref_low: assert property (m34_r[1:0] != 2'h0 |=> !o_reference_output[2])
    else $error("input channel drives reference");
endmodule : timer_channel_mode_config_chk
`default_nettype wire

// ==== test/timer_channel_mode_config_test.sv ====
// self-checking bench for the channel mode block
// assumes design, checker and pin model are compiled before it
`timescale 1ns/1ps
`default_nettype none

module timer_channel_mode_config_test;
  // stimulus
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic ext_trig = 1'b0;
  logic [3:0] pin_level = 4'h0;
  logic trig_level = 1'b0;
  logic trig_chosen = 1'b1;
  logic [15:0] cnt = 16'h0000; // counter value seen by the compare logic
  logic upd = 1'b0; // update event pulse
  logic trg_ev = 1'b0; // trigger event pulse for the fast path
  // observed
  logic [31:0] rdata;
  logic [3:0] tin, ref_out, cap_ev, filt, chan_en;
  logic trig_src, trig_ok, dts;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int ev_cnt [4] = '{0, 0, 0, 0};
  // routed pin per channel and select code, bit 4 is the trigger
  logic [4:0] route_tab [12] = '{5'h01, 5'h02, 5'h10, 5'h01, 5'h02, 5'h10,
                                 5'h04, 5'h08, 5'h10, 5'h08, 5'h04, 5'h10};
  // compare cases: expected level, trigger level, channel byte
  logic [9:0] cmp_tab [5] = '{10'h250, 10'h040, 10'h1D0, 10'h350, 10'h2D0};

  timer_pin_model pins (.i_sys_clk(clk), .i_rst_b(rst_b), .i_pin_level(pin_level),
    .i_trig_level(trig_level), .i_trig_chosen(trig_chosen), .o_timer_input(tin),
    .o_internal_trigger_source(trig_src), .o_internal_trigger_chosen(trig_ok), .o_deadtime_sample_clock(dts));
  timer_channel_mode_config DUT (.i_sys_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wr_data(wdata),
    .i_wr_strobe(wr_stb), .i_rd_strobe(rd_stb), .o_rd_data(rdata), .i_timer_input(tin),
    .i_internal_trigger_source(trig_src), .i_internal_trigger_chosen(trig_ok), .i_deadtime_sample_clock(dts),
    .i_trigger_event(trg_ev), .i_filtered_external_trigger(ext_trig), .i_counter(cnt),
    .i_update_event(upd), .o_reference_output(ref_out), .o_capture_event(cap_ev), .o_filtered_input(filt),
    .o_channel_enable(chan_en));

  // clock
  initial begin
    forever #25 clk = ~clk;
  end

  // capture counters and hang guard
  always @(posedge clk) begin
    cycles++;
    for (int i = 0; i < 4; i++) begin
      if (cap_ev[i] === 1'b1) ev_cnt[i]++;
    end
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // one write cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr

  // one read cycle, data taken in the following cycle
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 check(rdata, e);
  endtask : rdc

  // raise the masked pins and trigger for two clocks
  task automatic pulse(input logic [4:0] m);
    @(posedge clk);
    pin_level <= m[3:0];
    trig_level <= m[4];
    repeat (2) @(posedge clk);
    pin_level <= 4'h0;
    trig_level <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse

  task automatic t_reset_values;
    rdc(8'h18, 32'h0);
    rdc(8'h1C, 32'h0);
    rdc(8'h40, 32'h0);
  endtask : t_reset_values

  // select fields hold while the channel is enabled
  task automatic t_select_lock;
    logic [7:0] a;
    for (int r = 0; r < 2; r++) begin
      a = r ? 8'h1C : 8'h18;
      wr(a, 32'h0101);
      wr(8'h20, r ? 32'hC : 32'h3);
      wr(a, 32'hFEFE);
      rdc(a, 32'hFDFD);
      wr(8'h20, 32'h0);
      wr(a, 32'hFEFE);
      rdc(a, 32'hFEFE);
    end
  endtask : t_select_lock

  // each select code reaches only its own source
  task automatic t_routing;
    int base;
    logic [4:0] m;
    for (int c = 0; c < 4; c++) begin
      for (int k = 1; k < 4; k++) begin
        m = route_tab[c * 3 + k - 1];
        wr(8'h20, 32'h0);
        wr(c < 2 ? 8'h18 : 8'h1C, 32'(k << (8 * (c % 2))));
        wr(8'h20, 32'(1 << c));
        #1 base = ev_cnt[c];
        pulse(m);
        pulse(~m);
        repeat (4) @(posedge clk);
        #1 check(32'(ev_cnt[c] - base), 32'h1);
      end
    end
    @(posedge clk);
    trig_chosen <= 1'b0;
    #1 base = ev_cnt[3];
    pulse(5'h10);
    repeat (4) @(posedge clk);
    trig_chosen <= 1'b1;
    #1 check(32'(ev_cnt[3] - base), 32'h0);
  endtask : t_routing

  // eight events give 8, 4, 2, 1 captures
  task automatic t_prescale;
    int base;
    for (int ch = 0; ch < 2; ch++) begin
      for (int p = 0; p < 4; p++) begin
        wr(8'h20, 32'h0);
        wr(8'h18, 32'((p * 4 + 1) << (8 * ch)));
        wr(8'h20, 32'(1 << ch));
        #1 base = ev_cnt[ch];
        repeat (8) pulse(5'h01);
        repeat (4) @(posedge clk);
        #1 check(32'(ev_cnt[ch] - base), 32'(8 >> p));
      end
    end
  endtask : t_prescale

  // short filter drops a glitch, long filter waits its full length
  task automatic t_filter;
    wr(8'h20, 32'h0);
    wr(8'h18, 32'h0011);
    @(posedge clk);
    pin_level <= 4'h1;
    @(posedge clk);
    pin_level <= 4'h0;
    repeat (6) @(posedge clk);
    #1 check({31'h0, filt[0]}, 32'h0);
    @(posedge clk);
    pin_level <= 4'h1;
    repeat (6) @(posedge clk);
    #1 check({31'h0, filt[0]}, 32'h1);
    wr(8'h18, 32'h00F1);
    repeat (200) @(posedge clk);
    #1 check({31'h0, filt[0]}, 32'h1);
    @(posedge clk);
    pin_level <= 4'h0;
    repeat (200) @(posedge clk);
    #1 check({31'h0, filt[0]}, 32'h1);
    repeat (150) @(posedge clk);
    #1 check({31'h0, filt[0]}, 32'h0);
  endtask : t_filter

  // forced modes and trigger clear on ch3 and ch4
  task automatic t_compare;
    wr(8'h20, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(8'h1C, {16'h0, cmp_tab[i][7:0], cmp_tab[i][7:0]});
      ext_trig <= cmp_tab[i][8];
      repeat (3) @(posedge clk);
      #1 check({30'h0, ref_out[3:2]}, {30'h0, {2{cmp_tab[i][9]}}});
    end
  endtask : t_compare

  // one-cycle pulse on the update line (u high) or the trigger event line
  task automatic ev_pulse(input logic u);
    @(posedge clk);
    trg_ev <= !u;
    upd <= u;
    @(posedge clk);
    trg_ev <= 1'b0;
    upd <= 1'b0;
  endtask : ev_pulse

  // match, fast trigger, pwm, preload and status on ch3
  task automatic t_match;
    wr(8'h20, 32'h0);
    wr(8'h1C, 32'h0040);
    wr(8'h30, 32'h1234);
    rdc(8'h30, 32'h1234);
    wr(8'h1C, 32'h0014);
    repeat (2) @(posedge clk);
    #1 check({31'h0, ref_out[2]}, 32'h0);
    ev_pulse(1'b0);
    repeat (2) @(posedge clk);
    #1 check({31'h0, ref_out[2]}, 32'h1);
    wr(8'h1C, 32'h0020);
    ev_pulse(1'b0);
    repeat (2) @(posedge clk);
    #1 check({31'h0, ref_out[2]}, 32'h1);
    @(posedge clk);
    cnt <= 16'h1234;
    repeat (3) @(posedge clk);
    #1 check({31'h0, ref_out[2]}, 32'h0);
    wr(8'h1C, 32'h0028);
    wr(8'h30, 32'h0055);
    rdc(8'h30, 32'h1234);
    ev_pulse(1'b1);
    rdc(8'h30, 32'h0055);
    wr(8'h1C, 32'h0070);
    repeat (2) @(posedge clk);
    #1 check({31'h0, ref_out[2]}, 32'h1);
    rdc(8'h24, 32'h000000C0);
    wr(8'h1C, 32'h0060);
    repeat (2) @(posedge clk);
    #1 check({31'h0, ref_out[2]}, 32'h0);
  endtask : t_match

  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_reset_values();
    t_select_lock();
    t_routing();
    t_prescale();
    t_filter();
    t_compare();
    t_match();
    give_verdict();
  end
endmodule : timer_channel_mode_config_test

bind timer_channel_mode_config timer_channel_mode_config_chk chk (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
  .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_strobe(i_wr_strobe), .i_rd_strobe(i_rd_strobe),
  .o_rd_data(o_rd_data), .i_filtered_external_trigger(i_filtered_external_trigger),
  .o_reference_output(o_reference_output), .o_capture_event(o_capture_event), .o_channel_enable(o_channel_enable));
`default_nettype wire

// ==== test/timer_pin_model.sv ====
// model of the timer input pins and the internal trigger source
// assumes the bench asks for pin levels right after rising edges
`timescale 1ns/1ps
`default_nettype none

module timer_pin_model (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // requests from the bench
  input wire logic [3:0] i_pin_level,
  input wire logic i_trig_level,
  input wire logic i_trig_chosen,
  // lines toward the block
  output logic [3:0] o_timer_input,
  output logic o_internal_trigger_source,
  output logic o_internal_trigger_chosen,
  output logic o_deadtime_sample_clock
);
  // pins follow a request one clock later, as from a pad stage
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_timer_input <= 4'h0;
      o_internal_trigger_source <= 1'b0;
      o_internal_trigger_chosen <= 1'b0;
      o_deadtime_sample_clock <= 1'b0;
    end else begin
      o_timer_input <= i_pin_level;
      o_internal_trigger_source <= i_trig_level;
      o_internal_trigger_chosen <= i_trig_chosen;
      o_deadtime_sample_clock <= ~o_deadtime_sample_clock; // sample tick every other clock
    end
  end
endmodule : timer_pin_model
`default_nettype wire
